/* inc/ctp_timer_regs.vh */
`ifndef CTP_TIMER_REGS_VH
`define CTP_TIMER_REGS_VH

// Pair mode field codes.
`define CTP_MODE_8BIT 2'h0
`define CTP_MODE_16BIT 2'h1
`define CTP_MODE_PPG 2'h2
`define CTP_MODE_PWM 2'h3

// Lower clock select codes.
`define CTP_LCLK_EXT 2'h0
`define CTP_LCLK_DIV8 2'h1
`define CTP_LCLK_DIV32 2'h2
`define CTP_LCLK_DIV128 2'h3

// Upper clock select codes.
`define CTP_UCLK_CHAIN 2'h0
`define CTP_UCLK_DIV8 2'h1
`define CTP_UCLK_DIV128 2'h2
`define CTP_UCLK_DIV2048 2'h3

// PWM period select codes and the 2^n-1 tops they give.
`define CTP_PWM_UNUSED 2'h0
`define CTP_PWM_N6 2'h1
`define CTP_PWM_N7 2'h2
`define CTP_PWM_N8 2'h3
`define CTP_PWM_TOP6 8'h3F
`define CTP_PWM_TOP7 8'h7F
`define CTP_PWM_TOP8 8'hFF

// Toggle flop control codes.
`define CTP_FFC_INVERT 2'h0
`define CTP_FFC_CLEAR 2'h1
`define CTP_FFC_SET 2'h2
`define CTP_FFC_KEEP 2'h3

// Prescaler layout: a divide-by-four stage feeding a 9-bit divider.
`define CTP_PRE_WIDTH 9
`define CTP_PRE_FIRST_MAX 2'h3
`define CTP_PRE_MASK_DIV8 9'h001
`define CTP_PRE_MASK_DIV32 9'h007
`define CTP_PRE_MASK_DIV128 9'h01F
`define CTP_PRE_MASK_DIV2048 9'h1FF

// Reset values.
`define CTP_RST_COUNT 8'h00
`define CTP_RST_COMPARE 8'h00
`define CTP_RST_TOGGLE 1'b0
`define CTP_RST_SUSPEND 1'b0

`endif

/* design/ctp_prescaler.v */
`include "ctp_timer_regs.vh"

// Divides the system clock by four and then by a 9-bit binary divider.
// Each tap is a one-cycle pulse at its division ratio.
module ctp_prescaler (
  input wire clk,
  input wire nrst,
  input wire run,
  output wire tap_div8,
  output wire tap_div32,
  output wire tap_div128,
  output wire tap_div2048
);

  reg [1:0] first_q;
  reg [`CTP_PRE_WIDTH-1:0] div_q;
  reg [3:0] tap_q;
  wire stage_wrap;

  // A tap fires when the first stage wraps and the low divider bits are all ones.
  function tap_hit;
    input [`CTP_PRE_WIDTH-1:0] cnt;
    input [`CTP_PRE_WIDTH-1:0] mask;
    begin
      tap_hit = ((cnt & mask) == mask);
    end
  endfunction

  assign stage_wrap = (first_q == `CTP_PRE_FIRST_MAX);

  // Clearing the run bit stops and zeroes the whole divider.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_q <= 2'h0;
      div_q <= {`CTP_PRE_WIDTH{1'b0}};
      tap_q <= 4'h0;
    end else if (!run) begin
      first_q <= 2'h0;
      div_q <= {`CTP_PRE_WIDTH{1'b0}};
      tap_q <= 4'h0;
    end else begin
      first_q <= first_q + 2'h1;
      if (stage_wrap) begin
        div_q <= div_q + {{(`CTP_PRE_WIDTH-1){1'b0}}, 1'b1};
      end
      tap_q[0] <= stage_wrap & tap_hit(div_q, `CTP_PRE_MASK_DIV8);
      tap_q[1] <= stage_wrap & tap_hit(div_q, `CTP_PRE_MASK_DIV32);
      tap_q[2] <= stage_wrap & tap_hit(div_q, `CTP_PRE_MASK_DIV128);
      tap_q[3] <= stage_wrap & tap_hit(div_q, `CTP_PRE_MASK_DIV2048);
    end
  end

  assign tap_div8 = tap_q[0];
  assign tap_div32 = tap_q[1];
  assign tap_div128 = tap_q[2];
  assign tap_div2048 = tap_q[3];

endmodule

/* design/ctp_timer_pair.v */
// Overview of operation
// - Chained 8-bit mode, upper clock select 00: upper counts each lower match.
// - Pair mode 01 joins both counters into one 16-bit timer; pairs independent.
// - In 16-bit mode upper counter steps on lower overflow, ignoring its select.
// - In 16-bit mode lower compare write suspends joint match; upper write resumes it.
// - 16-bit mode lower match gives match signal only, no clear, no interrupt.
// - 16-bit joint match clears both, raises upper interrupt, may invert flop.
// - Chained mode lower clears and interrupts on each match; period is product.
// - Pulse mode uses lower timer only, output on toggle pin; upper unusable.
// - Pulse mode toggles on lower and upper compare; upper match clears counter.
// - Pulse mode double buffer copies lower buffer to active on upper match.
// - Pulse polarity is chosen by the initial toggle flop setting.
// - PWM toggles on lower match and on 2^n-1 overflow, which clears counter.
// - PWM period select 01, 10, 11 give n of 6, 7, 8; 00 unused.
// - PWM double buffer copies lower buffer to active on each overflow.
// - During PWM the upper runs as 8-bit timer on taps 8, 128, 2048.
// - Pair mode 00 8-bit, 01 16-bit, 10 pulse, 11 PWM with upper timer.
// - Lower clock select 00 external, 01 /8, 10 /32, 11 /128.
// - In 8-bit mode 00 inversion source 0 picks lower match, 1 upper match; PWM ignores it.
// - Prescaler divides by four then 9 bits; run bit low stops and zeroes.
// - Match clears counter and interrupts; compare 00 matches on overflow.
// - Flop control 01 clears, 10 sets, 00 inverts the toggle flop.
// - Double buffer off writes buffer and active; on writes buffer only.
`include "ctp_timer_regs.vh"

module ctp_timer_pair #(
  parameter HAS_EXT_INPUT = 1
) (
  input wire clk,
  input wire nrst,
  input wire [1:0] pair_mode_field,
  input wire [1:0] pwm_period_select,
  input wire [1:0] upper_clock_select,
  input wire [1:0] lower_clock_select,
  input wire inversion_source_select,
  input wire toggle_invert_enable,
  input wire toggle_flop_control_wr,
  input wire [1:0] toggle_flop_control,
  input wire lower_counter_run,
  input wire upper_counter_run,
  input wire prescaler_run,
  input wire compare_buffer_control,
  input wire lower_compare_wr,
  input wire upper_compare_wr,
  input wire [7:0] compare_wdata,
  input wire ext_count_in,
  output wire toggle_output_pin,
  output wire lower_match_interrupt,
  output wire upper_match_interrupt,
  output wire lower_match_signal,
  output wire [7:0] lower_up_counter,
  output wire [7:0] upper_up_counter,
  output wire compare_suspended
);

  // Counters, compare registers and the toggle flop.
  reg [7:0] lower_up_counter_q;
  reg [7:0] lower_up_counter_d;
  reg [7:0] upper_up_counter_q;
  reg [7:0] upper_up_counter_d;
  reg [7:0] lower_compare_value_q;
  reg [7:0] lower_compare_value_d;
  reg [7:0] lower_compare_buffer_q;
  reg [7:0] lower_compare_buffer_d;
  reg [7:0] upper_compare_value_q;
  reg [7:0] upper_compare_value_d;
  reg suspend_q;
  reg suspend_d;
  reg toggle_output_flop_q;
  reg toggle_output_flop_d;
  reg lower_irq_q;
  reg lower_irq_d;
  reg upper_irq_q;
  reg upper_irq_d;
  reg lower_match_q;
  reg lower_match_d;

  // External input synchroniser and edge detector.
  reg ext_meta_q;
  reg ext_sync_q;
  reg ext_prev_q;
  wire ext_edge;

  // Prescaler taps.
  wire prescale_tap_div8;
  wire prescale_tap_div32;
  wire prescale_tap_div128;
  wire prescale_tap_div2048;

  // Working values of the next-state logic.
  reg lower_tick;
  reg upper_tick;
  reg [7:0] lower_next;
  reg [7:0] upper_next;
  reg [7:0] upper_cand;
  reg [7:0] pwm_top;
  reg lower_hit;
  reg upper_hit;
  reg pwm_overflow;
  reg flip;

  // Increment shared by both counters; wraps from FF to 00.
  function [7:0] inc8;
    input [7:0] v;
    begin
      inc8 = v + 8'h01;
    end
  endfunction

  // Top value of the PWM counter for a period select code.
  function [7:0] pwm_limit;
    input [1:0] sel;
    begin
      case (sel)
        `CTP_PWM_N6: pwm_limit = `CTP_PWM_TOP6;
        `CTP_PWM_N7: pwm_limit = `CTP_PWM_TOP7;
        `CTP_PWM_N8: pwm_limit = `CTP_PWM_TOP8;
        default: pwm_limit = `CTP_PWM_TOP8;
      endcase
    end
  endfunction

  // Each pair keeps its own prescaler for the tap pulses.
  ctp_prescaler u_prescaler (
    .clk(clk),
    .nrst(nrst),
    .run(prescaler_run),
    .tap_div8(prescale_tap_div8),
    .tap_div32(prescale_tap_div32),
    .tap_div128(prescale_tap_div128),
    .tap_div2048(prescale_tap_div2048)
  );

  // Two flops bring the pin into the clock domain; a third finds rising edges.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_count_in;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // Rising edges of the synchronised pin become one-cycle count enables.
  assign ext_edge = ext_sync_q & ~ext_prev_q & (HAS_EXT_INPUT != 0);

  // Lower counter clock choice; a pair without the pin never counts on 00.
  always @* begin
    case (lower_clock_select)
      `CTP_LCLK_EXT: lower_tick = ext_edge;
      `CTP_LCLK_DIV8: lower_tick = prescale_tap_div8;
      `CTP_LCLK_DIV32: lower_tick = prescale_tap_div32;
      `CTP_LCLK_DIV128: lower_tick = prescale_tap_div128;
      default: lower_tick = 1'b0;
    endcase
  end

  // Next state for counters, compares, flop and interrupt pulses.
  always @* begin
    lower_next = inc8(lower_up_counter_q);
    upper_next = inc8(upper_up_counter_q);
    upper_cand = upper_up_counter_q;
    pwm_top = pwm_limit(pwm_period_select);
    lower_up_counter_d = lower_up_counter_q;
    upper_up_counter_d = upper_up_counter_q;
    lower_compare_value_d = lower_compare_value_q;
    lower_compare_buffer_d = lower_compare_buffer_q;
    upper_compare_value_d = upper_compare_value_q;
    suspend_d = suspend_q;
    toggle_output_flop_d = toggle_output_flop_q;
    lower_hit = 1'b0;
    upper_hit = 1'b0;
    upper_tick = 1'b0;
    pwm_overflow = 1'b0;
    flip = 1'b0;
    lower_irq_d = 1'b0;
    upper_irq_d = 1'b0;
    case (pair_mode_field)
      `CTP_MODE_8BIT: begin
        // Lower runs on its own; a compare of 00 meets the count at wrap.
        if (lower_tick && lower_counter_run) begin
          lower_hit = (lower_next == lower_compare_value_q);
          lower_up_counter_d = lower_hit ? `CTP_RST_COUNT : lower_next;
          lower_irq_d = lower_hit;
        end
      end
      `CTP_MODE_16BIT: begin
        // The lower byte never clears by itself; its wrap steps the upper byte.
        if (lower_tick && lower_counter_run) begin
          lower_hit = (lower_next == lower_compare_value_q);
          lower_up_counter_d = lower_next;
          if (lower_up_counter_q == 8'hFF) begin
            upper_cand = upper_next;
          end
          if (upper_counter_run) begin
            upper_up_counter_d = upper_cand;
          end
          upper_hit = (upper_cand == upper_compare_value_q);
          if (lower_hit && upper_hit && !suspend_q) begin
            lower_up_counter_d = `CTP_RST_COUNT;
            upper_up_counter_d = `CTP_RST_COUNT;
            upper_irq_d = 1'b1;
            flip = toggle_invert_enable;
          end
          // Only a joint match outside suspension counts as the upper match.
          upper_hit = upper_hit & lower_hit & ~suspend_q;
        end
      end
      `CTP_MODE_PPG: begin
        // The lower counter needs the upper run bit as well.
        if (lower_tick && lower_counter_run && upper_counter_run) begin
          lower_hit = (lower_next == lower_compare_value_q);
          upper_hit = (lower_next == upper_compare_value_q);
          lower_up_counter_d = upper_hit ? `CTP_RST_COUNT : lower_next;
          flip = toggle_invert_enable & (lower_hit | upper_hit);
          lower_irq_d = upper_hit;
          if (upper_hit && compare_buffer_control) begin
            lower_compare_value_d = lower_compare_buffer_q;
          end
        end
        upper_up_counter_d = `CTP_RST_COUNT;
      end
      `CTP_MODE_PWM: begin
        // The overflow takes priority, so a compare equal to the top gives no lower match pulse.
        if (lower_tick && lower_counter_run) begin
          pwm_overflow = (lower_next == pwm_top);
          lower_hit = (lower_next == lower_compare_value_q) & ~pwm_overflow;
          lower_up_counter_d = pwm_overflow ? `CTP_RST_COUNT : lower_next;
          flip = toggle_invert_enable & (lower_hit | pwm_overflow);
          lower_irq_d = pwm_overflow;
          if (pwm_overflow && compare_buffer_control) begin
            lower_compare_value_d = lower_compare_buffer_q;
          end
        end
      end
      default: begin
        lower_up_counter_d = lower_up_counter_q;
      end
    endcase

    // Upper counter as a plain 8-bit timer in chained and PWM modes.
    if (pair_mode_field == `CTP_MODE_8BIT || pair_mode_field == `CTP_MODE_PWM) begin
      case (upper_clock_select)
        `CTP_UCLK_CHAIN: upper_tick = (pair_mode_field == `CTP_MODE_8BIT) & lower_hit;
        `CTP_UCLK_DIV8: upper_tick = prescale_tap_div8;
        `CTP_UCLK_DIV128: upper_tick = prescale_tap_div128;
        `CTP_UCLK_DIV2048: upper_tick = prescale_tap_div2048;
        default: upper_tick = 1'b0;
      endcase
      if (upper_tick && upper_counter_run) begin
        upper_hit = (upper_next == upper_compare_value_q);
        upper_up_counter_d = upper_hit ? `CTP_RST_COUNT : upper_next;
        upper_irq_d = upper_hit;
      end
      if (pair_mode_field == `CTP_MODE_8BIT) begin
        flip = toggle_invert_enable & (inversion_source_select ? upper_hit : lower_hit);
      end
    end

    // A cleared run bit zeroes its counter; settings stay as they are.
    if (!lower_counter_run) begin
      lower_up_counter_d = `CTP_RST_COUNT;
    end
    if (!upper_counter_run) begin
      upper_up_counter_d = `CTP_RST_COUNT;
    end

    // A buffer copy in the same cycle takes the old buffer; a lower write goes to the buffer.
    if (lower_compare_wr) begin
      lower_compare_buffer_d = compare_wdata;
      if (!compare_buffer_control) begin
        lower_compare_value_d = compare_wdata;
      end
      suspend_d = 1'b1;
    end
    if (upper_compare_wr) begin
      upper_compare_value_d = compare_wdata;
      suspend_d = 1'b0;
    end

    // Hardware inversion, then a software force or invert wins over it.
    if (flip) begin
      toggle_output_flop_d = ~toggle_output_flop_q;
    end
    if (toggle_flop_control_wr) begin
      case (toggle_flop_control)
        `CTP_FFC_INVERT: toggle_output_flop_d = ~toggle_output_flop_q;
        `CTP_FFC_CLEAR: toggle_output_flop_d = 1'b0;
        `CTP_FFC_SET: toggle_output_flop_d = 1'b1;
        default: toggle_output_flop_d = toggle_output_flop_d;
      endcase
    end

    // The match pulse follows every lower equality, in 16-bit mode too, except at a PWM overflow.
    lower_match_d = lower_hit;
  end

  // State registers.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lower_up_counter_q <= `CTP_RST_COUNT;
      upper_up_counter_q <= `CTP_RST_COUNT;
      lower_compare_value_q <= `CTP_RST_COMPARE;
      lower_compare_buffer_q <= `CTP_RST_COMPARE;
      upper_compare_value_q <= `CTP_RST_COMPARE;
      suspend_q <= `CTP_RST_SUSPEND;
      toggle_output_flop_q <= `CTP_RST_TOGGLE;
      lower_irq_q <= 1'b0;
      upper_irq_q <= 1'b0;
      lower_match_q <= 1'b0;
    end else begin
      lower_up_counter_q <= lower_up_counter_d;
      upper_up_counter_q <= upper_up_counter_d;
      lower_compare_value_q <= lower_compare_value_d;
      lower_compare_buffer_q <= lower_compare_buffer_d;
      upper_compare_value_q <= upper_compare_value_d;
      suspend_q <= suspend_d;
      toggle_output_flop_q <= toggle_output_flop_d;
      lower_irq_q <= lower_irq_d;
      upper_irq_q <= upper_irq_d;
      lower_match_q <= lower_match_d;
    end
  end

  // Outputs come straight from flops.
  assign toggle_output_pin = toggle_output_flop_q;
  assign lower_match_interrupt = lower_irq_q;
  assign upper_match_interrupt = upper_irq_q;
  assign lower_match_signal = lower_match_q;
  assign lower_up_counter = lower_up_counter_q;
  assign upper_up_counter = upper_up_counter_q;
  assign compare_suspended = suspend_q;

endmodule

/* test/ctp_timer_pair_sva.sv */
`include "ctp_timer_regs.vh"

// Watches one timer pair at its ports.
module ctp_timer_pair_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] pair_mode_field,
  input wire logic [1:0] pwm_period_select,
  input wire logic [1:0] upper_clock_select,
  input wire logic [1:0] lower_clock_select,
  input wire logic inversion_source_select,
  input wire logic toggle_invert_enable,
  input wire logic toggle_flop_control_wr,
  input wire logic [1:0] toggle_flop_control,
  input wire logic lower_counter_run,
  input wire logic upper_counter_run,
  input wire logic prescaler_run,
  input wire logic compare_buffer_control,
  input wire logic lower_compare_wr,
  input wire logic upper_compare_wr,
  input wire logic [7:0] compare_wdata,
  input wire logic ext_count_in,
  input wire logic toggle_output_pin,
  input wire logic lower_match_interrupt,
  input wire logic upper_match_interrupt,
  input wire logic lower_match_signal,
  input wire logic [7:0] lower_up_counter,
  input wire logic [7:0] upper_up_counter,
  input wire logic compare_suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Mode and event relations, each tied to its cause.
  property p_irq16;
    pair_mode_field == `CTP_MODE_16BIT && $past(pair_mode_field) == `CTP_MODE_16BIT |-> !lower_match_interrupt;
  endproperty
  a_irq16: assert property (p_irq16) else $error("lower interrupt in wide mode");
  property p_joint;
    pair_mode_field == `CTP_MODE_16BIT && upper_match_interrupt |-> lower_up_counter == 8'h00 && upper_up_counter == 8'h00;
  endproperty
  a_joint: assert property (p_joint) else $error("wide match left a counter set");
  property p_ppgup;
    pair_mode_field == `CTP_MODE_PPG && $past(pair_mode_field) == `CTP_MODE_PPG |-> upper_up_counter == 8'h00;
  endproperty
  a_ppgup: assert property (p_ppgup) else $error("upper counter moved in pulse mode");
  property p_clr8;
    pair_mode_field == `CTP_MODE_8BIT && lower_match_interrupt |-> lower_up_counter == 8'h00 && lower_match_signal;
  endproperty
  a_clr8: assert property (p_clr8) else $error("lower match did not clear");
  property p_pulse;
    lower_match_interrupt |=> !lower_match_interrupt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt longer than one cycle");
  property p_pwm6;
    pair_mode_field == `CTP_MODE_PWM && pwm_period_select == `CTP_PWM_N6 && $past(pwm_period_select) == `CTP_PWM_N6
      && $past(pair_mode_field) == `CTP_MODE_PWM && lower_match_interrupt |-> $past(lower_up_counter) == 8'h3E;
  endproperty
  a_pwm6: assert property (p_pwm6) else $error("pwm overflow at wrong count");
  property p_susp;
    lower_compare_wr && !upper_compare_wr |=> compare_suspended;
  endproperty
  a_susp: assert property (p_susp) else $error("lower write did not suspend");
  property p_resume;
    upper_compare_wr |=> !compare_suspended;
  endproperty
  a_resume: assert property (p_resume) else $error("upper write did not resume");
  property p_ffclr;
    toggle_flop_control_wr && toggle_flop_control == `CTP_FFC_CLEAR |=> !toggle_output_pin;
  endproperty
  a_ffclr: assert property (p_ffclr) else $error("toggle clear failed");
  property p_stop;
    !lower_counter_run && !$past(lower_counter_run) |-> lower_up_counter == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter not zero");
  property p_div8;
    $changed(lower_up_counter) && lower_clock_select == `CTP_LCLK_DIV8 && lower_counter_run
      |=> ($stable(lower_up_counter) || !lower_counter_run) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("lower counter faster than tap");

  // Main scenarios reached.
  c_joint: cover property (pair_mode_field == `CTP_MODE_16BIT && upper_match_interrupt);
  c_ppg: cover property (pair_mode_field == `CTP_MODE_PPG && $changed(toggle_output_pin));
  c_pwm: cover property (pair_mode_field == `CTP_MODE_PWM && lower_match_interrupt);
endmodule

bind ctp_timer_pair ctp_timer_pair_sva u_sva (.*);

/* test/ctp_ext_src.sv */
// External count source: square wave of eight system clocks while enabled.
module ctp_ext_src (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  output logic ext_count_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q;

  // Phase counter; the line rests low outside bursts.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) ph_q <= 3'h0;
    else ph_q <= en ? ph_q + 3'h1 : 3'h0;
  end
  assign ext_count_in = en & ph_q[2];
endmodule

/* test/tb.sv */
`include "ctp_timer_regs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, inversion_source_select, toggle_invert_enable, toggle_flop_control_wr;
  logic lower_counter_run, upper_counter_run, prescaler_run, compare_buffer_control;
  logic lower_compare_wr, upper_compare_wr, ext_count_in, toggle_output_pin, ext_en;
  logic lower_match_interrupt, upper_match_interrupt, lower_match_signal, compare_suspended;
  logic [1:0] pair_mode_field, pwm_period_select, upper_clock_select, lower_clock_select, toggle_flop_control;
  logic [7:0] compare_wdata, lower_up_counter, upper_up_counter;
  int failures, comparisons, cyc;

  ctp_timer_pair #(.HAS_EXT_INPUT(1)) dut (.*);
  ctp_ext_src u_src (.clk(clk), .nrst(nrst), .en(ext_en), .ext_count_in(ext_count_in));

  // System clock at 50 MHz.
  always #10 clk = ~clk;

  // Cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task close_out();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Waits for lower irq (0), upper irq (1), a toggle change (2) or a lower match pulse (3).
  task automatic wait_ev(input int s, output int n);
    logic t0;
    t0 = toggle_output_pin;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 5000 && !(s == 0 ? lower_match_interrupt === 1'b1 :
               s == 1 ? upper_match_interrupt === 1'b1 : s == 2 ? toggle_output_pin !== t0 :
               lower_match_signal === 1'b1));
  endtask

  task automatic gap(input int s, input int exp);
    int n;
    wait_ev(s, n);
    wait_ev(s, n);
    chk(n, exp);
  endtask

  // Stops both counters, then sets the mode fields.
  task automatic cfg(input logic [1:0] m, input logic [1:0] lc, input logic [1:0] uc, input logic [1:0] pw);
    @(posedge clk);
    lower_counter_run <= 1'b0;
    upper_counter_run <= 1'b0;
    repeat (2) @(posedge clk);
    pair_mode_field <= m;
    lower_clock_select <= lc;
    upper_clock_select <= uc;
    pwm_period_select <= pw;
  endtask

  task automatic go();
    @(posedge clk);
    lower_counter_run <= 1'b1;
    upper_counter_run <= 1'b1;
  endtask

  task automatic wcmp(input logic hi, input logic [7:0] v);
    @(posedge clk);
    lower_compare_wr <= !hi;
    upper_compare_wr <= hi;
    compare_wdata <= v;
    @(posedge clk);
    lower_compare_wr <= 1'b0;
    upper_compare_wr <= 1'b0;
  endtask

  task automatic tff(input logic [1:0] code);
    @(posedge clk);
    toggle_flop_control_wr <= 1'b1;
    toggle_flop_control <= code;
    @(posedge clk);
    toggle_flop_control_wr <= 1'b0;
  endtask

  task automatic s_eight();
    logic [7:0] v;
    cfg(`CTP_MODE_8BIT, `CTP_LCLK_DIV8, `CTP_UCLK_DIV8, 2'h0);
    wcmp(1'b0, 8'h03);
    go();
    gap(0, 24);
    chk(lower_up_counter, 8'h00);
    gap(2, 24);
    @(posedge clk);
    prescaler_run <= 1'b0;
    repeat (3) @(posedge clk);
    #1 v = lower_up_counter;
    repeat (40) @(posedge clk);
    #1 chk(lower_up_counter, v);
    @(posedge clk);
    prescaler_run <= 1'b1;
  endtask

  task automatic s_chain();
    cfg(`CTP_MODE_8BIT, `CTP_LCLK_DIV8, `CTP_UCLK_CHAIN, 2'h0);
    inversion_source_select <= 1'b1;
    wcmp(1'b0, 8'h02);
    wcmp(1'b1, 8'h03);
    go();
    gap(1, 48);
    gap(2, 48);
    @(posedge clk);
    inversion_source_select <= 1'b0;
  endtask

  task automatic s_wide();
    int n;
    logic t;
    cfg(`CTP_MODE_16BIT, `CTP_LCLK_DIV8, `CTP_UCLK_DIV2048, 2'h0);
    wcmp(1'b0, 8'h05);
    #1 chk(compare_suspended, 1'b1);
    wcmp(1'b1, 8'h01);
    #1 chk(compare_suspended, 1'b0);
    go();
    gap(1, 2088);
    wait_ev(3, n);
    chk(n, 40);
    chk(lower_up_counter, 8'h05);
    wait_ev(2, n);
    chk(n, 2048);
    @(posedge clk);
    toggle_invert_enable <= 1'b0;
    #1 t = toggle_output_pin;
    wait_ev(1, n);
    chk(toggle_output_pin, t);
    @(posedge clk);
    toggle_invert_enable <= 1'b1;
  endtask

  task automatic s_ppg();
    int n;
    cfg(`CTP_MODE_PPG, `CTP_LCLK_DIV8, `CTP_UCLK_DIV8, 2'h0);
    wcmp(1'b0, 8'h03);
    wcmp(1'b1, 8'h08);
    tff(`CTP_FFC_CLEAR);
    #1 chk(toggle_output_pin, 1'b0);
    tff(`CTP_FFC_SET);
    #1 chk(toggle_output_pin, 1'b1);
    tff(`CTP_FFC_INVERT);
    #1 chk(toggle_output_pin, 1'b0);
    tff(`CTP_FFC_INVERT);
    #1 chk(toggle_output_pin, 1'b1);
    go();
    wait_ev(0, n);
    wait_ev(2, n);
    chk(n, 24);
    wait_ev(2, n);
    chk(n, 40);
    @(posedge clk);
    compare_buffer_control <= 1'b1;
    wcmp(1'b0, 8'h05);
    wait_ev(0, n);
    wait_ev(2, n);
    chk(n, 40);
    @(posedge clk);
    compare_buffer_control <= 1'b0;
  endtask

  task automatic s_pwm();
    int n;
    for (int i = 1; i < 4; i++) begin
      cfg(`CTP_MODE_PWM, `CTP_LCLK_DIV8, i[1:0], i[1:0]);
      wcmp(1'b0, 8'h10);
      wcmp(1'b1, 8'h01);
      go();
      gap(0, ((1 << (i + 5)) - 1) * 8);
      wait_ev(2, n);
      chk(n, 128);
      gap(1, 8 << (4 * (i - 1)));
    end
  endtask

  task automatic s_ext();
    cfg(`CTP_MODE_8BIT, `CTP_LCLK_EXT, `CTP_UCLK_DIV8, 2'h0);
    wcmp(1'b0, 8'h02);
    ext_en <= 1'b1;
    go();
    gap(0, 16);
    @(posedge clk);
    ext_en <= 1'b0;
  endtask

  // Lower counter on the divide-by-32 and divide-by-128 taps.
  task automatic s_div();
    for (int j = 2; j < 4; j++) begin
      cfg(`CTP_MODE_8BIT, j[1:0], `CTP_UCLK_DIV8, 2'h0);
      wcmp(1'b0, 8'h02);
      go();
      gap(0, 16 << (2 * j - 2));
    end
  endtask

  // Reset, then each scenario in turn.
  initial begin
    {clk, nrst, inversion_source_select, toggle_flop_control_wr, lower_counter_run} = '0;
    {upper_counter_run, compare_buffer_control, lower_compare_wr, upper_compare_wr, ext_en} = '0;
    {pair_mode_field, pwm_period_select, upper_clock_select, lower_clock_select} = '0;
    toggle_flop_control = 2'h3;
    compare_wdata = 8'h00;
    toggle_invert_enable = 1'b1;
    prescaler_run = 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk(toggle_output_pin, 1'b0);
    s_eight();
    s_chain();
    s_wide();
    s_ppg();
    s_pwm();
    s_ext();
    s_div();
    close_out();
  end
endmodule
